// *** design/monitor_txctl_config_regs.vh ***
`ifndef MONITOR_TXCTL_CONFIG_REGS_VH
`define MONITOR_TXCTL_CONFIG_REGS_VH
// ==========================================
// Register offsets
`define OFS_RSSI_TXD_FAULT_CONFIG 8'h8B
`define OFS_RESERVED_8C           8'h8C
`define OFS_DAC_POWER_LEVEL_CONFIG 8'h8D
`define OFS_TX_MONITOR_RIGHT_SHIFT 8'h8E
// ==========================================
// Reset values
`define RST_RSSI_TXD_FAULT_CONFIG 8'h10
`define RST_DAC_POWER_LEVEL_CONFIG 8'h00
`define RST_TX_MONITOR_RIGHT_SHIFT 8'h00
// ==========================================
// Field positions
`define BIT_CROSSOVER_ENABLE      7
`define BIT_DISABLE_CLEARS_ALARMS 5
`define BIT_OVERFLOW_FAULT_ENABLE 4
`define BIT_FAULT_TO_DISABLE      3
`define BIT_DISABLE_INPUT_IGNORE  2
`define BIT_FORCE_COARSE          1
`define BIT_FORCE_FINE            0
`define BIT_DAC_POLARITY          7
`define BIT_LEGACY_LEVEL_MODE     3
`define MASK_CONFIG_C             8'hBF
`define MASK_CONFIG_D             8'h8F
`define MASK_SHIFT                8'h77
`define FLD_BIAS_SHIFT_LSB        4
`define FLD_POWER_SHIFT_LSB       0
`define FLD_LEGACY_LEVEL_LSB      0
// ==========================================
// Level codes
`define LEVEL_0DB                 2'h0
`define LEVEL_3DB                 2'h1
`define LEVEL_6DB                 2'h2
`endif

// *** design/nv_config_store.v ***
`timescale 1ns/100ps
// ==========================================
// Nonvolatile image of one config byte
module nv_config_store #(
    parameter [7:0] FACTORY = 8'h00,
    parameter [7:0] MASK    = 8'hFF
) (
    input  wire       clk_in,
    input  wire       rst_b_in,
    input  wire       wr_in,
    input  wire [7:0] wdata_in,
    input  wire       load_in,
    input  wire [7:0] nv_in,
    output reg  [7:0] value_out
);
    // Reset gives factory value; load recalls stored image; reserved bits zero
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            value_out <= FACTORY & MASK;
        end else if (load_in) begin
            value_out <= nv_in & MASK;
        end else if (wr_in) begin
            value_out <= wdata_in & MASK;
        end
    end
endmodule

// *** design/monitor_txctl_config_regs.v ***
// Function
// - Crossover bit selects threshold versus hysteresis
// - Disable event holds RSSI alarms cleared
// - Driver overflow flags raise fault output
// - Fault input ORed into disable output
// - Disable input ORed unless ignore set
// - Force field picks normal, fine, coarse
// - DAC inverted when polarity bit zero
// - Mode zero uses lower-memory power level
// - Mode one writes legacy code to driver
// - Right-shift bias and power monitor results
// - Password and grant gate reads, writes
// - Coarse result clamped up to crossover
// - Fine above threshold requests coarse conversion
`timescale 1ns/100ps
`include "monitor_txctl_config_regs.vh"
module monitor_txctl_config_regs #(
    parameter MON_W = 16
) (
    input  wire             clk_in,
    input  wire             rst_b_in,
    // Host register access
    input  wire [7:0]       addr_in,
    input  wire             wr_in,
    input  wire             rd_in,
    input  wire [7:0]       wdata_in,
    output reg  [7:0]       rdata_out,
    output wire             denied_out,
    input  wire             factory_password_level_in,
    input  wire             user_password_level_in,
    input  wire             table_readwrite_grant_in,
    input  wire             table_read_grant_in,
    // Nonvolatile recall
    input  wire             nv_load_in,
    input  wire [7:0]       nv_config_c_in,
    input  wire [7:0]       nv_config_d_in,
    input  wire [7:0]       nv_shift_in,
    // Transmit pins and driver status
    input  wire             disable_in,
    input  wire             fault_in_pin_in,
    input  wire             bias_overflow_flag_in,
    input  wire             modulation_overflow_flag_in,
    input  wire             fault_other_in,
    output reg              disable_out_pin_out,
    output reg              fault_out_pin_out,
    output reg              rssi_alarm_clear_out,
    // RSSI conversion control
    input  wire [15:0]      crossover_threshold_fine_in,
    input  wire [15:0]      crossover_threshold_coarse_in,
    input  wire             hysteresis_coarse_in,
    input  wire [15:0]      rssi_fine_raw_in,
    input  wire [15:0]      rssi_coarse_raw_in,
    output reg              rssi_use_coarse_out,
    output reg  [15:0]      rssi_coarse_clamped_out,
    // DAC and laser driver level
    input  wire [9:0]       dac_raw_in,
    output reg  [9:0]       dac_out,
    input  wire [1:0]       lower_power_level_in,
    output reg  [1:0]       driver_level_field_out,
    output reg              driver_level_write_out,
    // Monitor results
    input  wire [MON_W-1:0] bias_monitor_in,
    input  wire [MON_W-1:0] power_monitor_in,
    output reg  [MON_W-1:0] bias_monitor_out,
    output reg  [MON_W-1:0] power_monitor_out
);
    // ==========================================
    // Access control
    wire       can_read;
    wire       can_write;
    wire       hit_c;
    wire       hit_d;
    wire       hit_s;
    wire [7:0] rssi_txd_fault_config;
    wire [7:0] dac_power_level_config;
    wire [7:0] tx_monitor_right_shift;

    // Top level alone, or lower level with a table grant (only the read-write grant for writes)
    assign can_read  = factory_password_level_in | (user_password_level_in &
                       (table_readwrite_grant_in | table_read_grant_in));
    assign can_write = factory_password_level_in |
                       (user_password_level_in & table_readwrite_grant_in);
    // Full byte compare; aliases of the bank would let a stray write land
    assign hit_c = (addr_in == `OFS_RSSI_TXD_FAULT_CONFIG);
    assign hit_d = (addr_in == `OFS_DAC_POWER_LEVEL_CONFIG);
    assign hit_s = (addr_in == `OFS_TX_MONITOR_RIGHT_SHIFT);
    // Refused access is flagged so the host can report it
    assign denied_out = (wr_in & ~can_write) | (rd_in & ~can_read);

    // ==========================================
    // Configuration storage, recalled from the nonvolatile image
    // Recall beats a host write in the same cycle, so the image always wins
    // Reserved bits are masked at storage, so reads and decode see zero
    nv_config_store #(.FACTORY(`RST_RSSI_TXD_FAULT_CONFIG), .MASK(`MASK_CONFIG_C)) u_cfg_c (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .wr_in     (wr_in & can_write & hit_c),
        .wdata_in  (wdata_in),
        .load_in   (nv_load_in),
        .nv_in     (nv_config_c_in),
        .value_out (rssi_txd_fault_config)
    );
    nv_config_store #(.FACTORY(`RST_DAC_POWER_LEVEL_CONFIG), .MASK(`MASK_CONFIG_D)) u_cfg_d (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .wr_in     (wr_in & can_write & hit_d),
        .wdata_in  (wdata_in),
        .load_in   (nv_load_in),
        .nv_in     (nv_config_d_in),
        .value_out (dac_power_level_config)
    );
    nv_config_store #(.FACTORY(`RST_TX_MONITOR_RIGHT_SHIFT), .MASK(`MASK_SHIFT)) u_shift (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .wr_in     (wr_in & can_write & hit_s),
        .wdata_in  (wdata_in),
        .load_in   (nv_load_in),
        .nv_in     (nv_shift_in),
        .value_out (tx_monitor_right_shift)
    );

    // ==========================================
    // Field decode
    wire       rssi_crossover_enable;
    wire       disable_clears_rssi_alarms;
    wire       overflow_fault_enable;
    wire       fault_to_disable_enable;
    wire       disable_input_ignore;
    wire [1:0] rssi_force;
    wire       dac_polarity;
    wire       legacy_level_mode;
    wire [2:0] legacy_power_level;
    wire [2:0] bias_shift;
    wire [2:0] power_shift;

    assign rssi_crossover_enable      = rssi_txd_fault_config[`BIT_CROSSOVER_ENABLE];
    assign disable_clears_rssi_alarms = rssi_txd_fault_config[`BIT_DISABLE_CLEARS_ALARMS];
    assign overflow_fault_enable      = rssi_txd_fault_config[`BIT_OVERFLOW_FAULT_ENABLE];
    assign fault_to_disable_enable    = rssi_txd_fault_config[`BIT_FAULT_TO_DISABLE];
    assign disable_input_ignore       = rssi_txd_fault_config[`BIT_DISABLE_INPUT_IGNORE];
    assign rssi_force = {rssi_txd_fault_config[`BIT_FORCE_COARSE],
                         rssi_txd_fault_config[`BIT_FORCE_FINE]};
    assign dac_polarity       = dac_power_level_config[`BIT_DAC_POLARITY];
    assign legacy_level_mode  = dac_power_level_config[`BIT_LEGACY_LEVEL_MODE];
    assign legacy_power_level = dac_power_level_config[`FLD_LEGACY_LEVEL_LSB +: 3];
    // Shift fields sit in the low three bits of each nibble
    assign bias_shift         = tx_monitor_right_shift[`FLD_BIAS_SHIFT_LSB +: 3];
    assign power_shift        = tx_monitor_right_shift[`FLD_POWER_SHIFT_LSB +: 3];

    // ==========================================
    // Next values for outputs
    reg              next_disable;
    reg              next_fault;
    reg              next_use_coarse;
    reg [15:0]       next_clamped;
    reg [1:0]        next_level;
    reg              disable_event;

    // Transmit disable and fault routing
    // Plain OR of levels; a glitch on an enabled input reaches the pin
    always @* begin
        next_fault = fault_other_in |
                     (overflow_fault_enable &
                      (bias_overflow_flag_in | modulation_overflow_flag_in));
        next_disable = (~disable_input_ignore & disable_in)
                     | (fault_to_disable_enable & fault_in_pin_in);
        disable_event = disable_in;
    end

    // RSSI range choice: forced codes win, then crossover or hysteresis
    // Limitation: the hysteresis decision itself is made outside this bank
    always @* begin
        case (rssi_force)
            2'h1: next_use_coarse = 1'b0;
            2'h2: next_use_coarse = 1'b1;
            default: begin
                if (rssi_crossover_enable) begin
                    next_use_coarse = (rssi_fine_raw_in >
                                       crossover_threshold_fine_in);
                end else begin
                    next_use_coarse = hysteresis_coarse_in;
                end
            end
        endcase
        // Clamp applies on raw result, before any shift
        if (rssi_crossover_enable && (rssi_coarse_raw_in < crossover_threshold_coarse_in)) begin
            next_clamped = crossover_threshold_coarse_in;
        end else begin
            next_clamped = rssi_coarse_raw_in;
        end
    end

    // Legacy level mapping onto the driver level field
    // Codes past the middle band all fold into the deepest step
    always @* begin
        if (legacy_level_mode) begin
            case (legacy_power_level)
                3'h0, 3'h1, 3'h2: next_level = `LEVEL_0DB;
                3'h3, 3'h4, 3'h5: next_level = `LEVEL_3DB;
                default:          next_level = `LEVEL_6DB;
            endcase
        end else begin
            next_level = lower_power_level_in;
        end
    end

    // ==========================================
    // Read data selection
    reg [7:0]       next_rdata;
    reg [9:0]       next_dac;
    reg [MON_W-1:0] next_bias_monitor;
    reg [MON_W-1:0] next_power_monitor;
    reg             next_alarm_clear;

    // Reads without access and unmapped or reserved bytes return zero
    always @* begin
        next_rdata = 8'h00;
        if (rd_in && can_read) begin
            case (addr_in)
                `OFS_RSSI_TXD_FAULT_CONFIG:  next_rdata = rssi_txd_fault_config;
                `OFS_DAC_POWER_LEVEL_CONFIG: next_rdata = dac_power_level_config;
                `OFS_TX_MONITOR_RIGHT_SHIFT: next_rdata = tx_monitor_right_shift;
                default:                     next_rdata = 8'h00;
            endcase
        end
    end

    // ==========================================
    // Analog side and monitor shaping
    // Polarity applied before the register so the DAC code never glitches
    always @* begin
        if (dac_polarity) begin
            next_dac = dac_raw_in;
        end else begin
            next_dac = ~dac_raw_in;
        end
        // Shift only; low bits are dropped, no rounding of the final result
        next_bias_monitor  = bias_monitor_in >> bias_shift;
        next_power_monitor = power_monitor_in >> power_shift;
        // Held for as long as the disable input stays high
        next_alarm_clear   = disable_clears_rssi_alarms & disable_event;
    end

    // ==========================================
    // Registered outputs
    // Transmit pins, one cycle behind their inputs
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            disable_out_pin_out  <= 1'b0;
            fault_out_pin_out    <= 1'b0;
            rssi_alarm_clear_out <= 1'b0;
        end else begin
            disable_out_pin_out  <= next_disable;
            fault_out_pin_out    <= next_fault;
            rssi_alarm_clear_out <= next_alarm_clear;
        end
    end

    // RSSI range choice and clamped coarse result
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            rssi_use_coarse_out     <= 1'b0;
            rssi_coarse_clamped_out <= 16'h0000;
        end else begin
            rssi_use_coarse_out     <= next_use_coarse;
            rssi_coarse_clamped_out <= next_clamped;
        end
    end

    // DAC code and driver level; the write strobe follows the mode bit
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            dac_out                <= 10'h000;
            driver_level_field_out <= `LEVEL_0DB;
            driver_level_write_out <= 1'b0;
        end else begin
            dac_out                <= next_dac;
            driver_level_field_out <= next_level;
            driver_level_write_out <= legacy_level_mode;
        end
    end

    // Shifted monitor results
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            bias_monitor_out  <= {MON_W{1'b0}};
            power_monitor_out <= {MON_W{1'b0}};
        end else begin
            bias_monitor_out  <= next_bias_monitor;
            power_monitor_out <= next_power_monitor;
        end
    end

    // Read data stands only in the cycle after the read strobe
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= next_rdata;
        end
    end
endmodule

// *** tb/config_regs_properties.sv ***
`timescale 1ns/100ps
// ==========================================
// Port checks on the config bank
module config_regs_properties (
    input wire       clk_in,
    input wire       rst_b_in,
    input wire [7:0] addr_in,
    input wire       wr_in,
    input wire       rd_in,
    input wire [7:0] wdata_in,
    input wire [7:0] rdata_out,
    input wire       denied_out,
    input wire       factory_password_level_in,
    input wire       user_password_level_in,
    input wire       table_readwrite_grant_in,
    input wire       table_read_grant_in,
    input wire       nv_load_in,
    input wire [7:0] nv_config_c_in,
    input wire       disable_in,
    input wire       fault_in_pin_in,
    input wire       bias_overflow_flag_in,
    input wire       modulation_overflow_flag_in,
    input wire       hysteresis_coarse_in,
    input wire       disable_out_pin_out,
    input wire       fault_out_pin_out,
    input wire       rssi_alarm_clear_out,
    input wire       rssi_use_coarse_out
);
    reg  [7:0] c;
    wire       user_rd = table_readwrite_grant_in | table_read_grant_in;
    wire       rd_ok = factory_password_level_in | (user_password_level_in & user_rd);
    wire       wr_ok = factory_password_level_in |
                       (user_password_level_in & table_readwrite_grant_in);
    wire       dis_exp = (disable_in & ~c[2]) | (fault_in_pin_in & c[3]);
    wire       clr_exp = disable_in & c[5];
    // Shadow of the first config byte; recall beats a host write
    always @(posedge clk_in) begin
        if (!rst_b_in)
            c <= 8'h10;
        else if (nv_load_in)
            c <= nv_config_c_in & 8'hBF;
        else if (wr_in && wr_ok && addr_in == 8'h8B)
            c <= wdata_in & 8'hBF;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // Antecedents other than the refused read and write checks need reset seen high, so those use no pre-reset state
    chk_disable_merge: assert property (
        rst_b_in |=> disable_out_pin_out == $past(dis_exp))
        else $error("disable output mismatch");
    chk_overflow_fault: assert property (
        rst_b_in && c[4] && (bias_overflow_flag_in || modulation_overflow_flag_in) |=> fault_out_pin_out)
        else $error("fault output missed overflow");
    chk_alarm_hold: assert property (rst_b_in |=> rssi_alarm_clear_out == $past(clr_exp))
        else $error("alarm clear mismatch");
    chk_force_coarse: assert property (
        rst_b_in && c[1:0] == 2'b10 |=> rssi_use_coarse_out)
        else $error("forced coarse not used");
    chk_force_fine: assert property (rst_b_in && c[1:0] == 2'b01 |=> !rssi_use_coarse_out)
        else $error("forced fine not used");
    chk_hysteresis_mode: assert property (
        rst_b_in && !c[7] && c[1] == c[0] |=> rssi_use_coarse_out == $past(hysteresis_coarse_in))
        else $error("hysteresis range mismatch");
    chk_read_refused: assert property (
        rd_in && !rd_ok |-> denied_out ##1 rdata_out == 8'h00)
        else $error("refused read leaked data");
    chk_write_refused: assert property (wr_in && !wr_ok |-> denied_out)
        else $error("refused write not flagged");
    chk_config_readback: assert property (
        rst_b_in && rd_in && rd_ok && addr_in == 8'h8B |=> rdata_out == $past(c))
        else $error("config read data mismatch");
    cover property (wr_in && wr_ok);
    cover property (rd_in && !rd_ok);
    cover property (nv_load_in);
    cover property (c[7] && rssi_use_coarse_out);
endmodule
bind monitor_txctl_config_regs config_regs_properties chk_u (.*);

// *** tb/config_host.sv ***
`timescale 1ns/100ps
// ==========================================
// Management host: single-byte reads and writes
module config_host (
    input  wire       clk_in,
    input  wire [7:0] rdata_in,
    input  wire       denied_in,
    output reg  [7:0] addr_out,
    output reg        wr_out,
    output reg        rd_out,
    output reg  [7:0] wdata_out
);
    // Idle bus at time zero
    initial {addr_out, wr_out, rd_out, wdata_out} = 18'h0;
    // Strobe held one cycle; released lines show the inverse, not stale data
    task automatic put(input [7:0] a, input [7:0] d, output den);
        begin
            @(posedge clk_in);
            addr_out <= a;
            wdata_out <= d;
            wr_out <= 1'b1;
            #1 den = denied_in;
            @(posedge clk_in);
            wr_out <= 1'b0;
            addr_out <= ~a;
            wdata_out <= ~d;
        end
    endtask
    // Read data stands one cycle only, so take it right after the edge
    task automatic get(input [7:0] a, output [7:0] q, output den);
        begin
            @(posedge clk_in);
            addr_out <= a;
            rd_out <= 1'b1;
            #1 den = denied_in;
            @(posedge clk_in);
            rd_out <= 1'b0;
            addr_out <= ~a;
            #1 q = rdata_in;
        end
    endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps
// ==========================================
// Bench for the monitor and transmit config bank
module testbench;
    reg         clk_in = 1'b0;
    reg         rst_b_in = 1'b0;
    reg         nv_load_in, disable_in, fault_in_pin_in, bias_overflow_flag_in;
    reg         modulation_overflow_flag_in, hysteresis_coarse_in, den, wok, rok;
    reg  [3:0]  grants = 4'h0;
    reg  [7:0]  nv_config_c_in, nv_config_d_in, nv_shift_in, cfg, q, sh;
    reg  [15:0] rssi_fine_raw_in, rssi_coarse_raw_in, bias_monitor_in, power_monitor_in, ex;
    reg  [15:0] crossover_threshold_fine, crossover_threshold_coarse;
    reg  [9:0]  dac_raw_in;
    reg  [1:0]  lower_power_level_in;
    wire [7:0]  addr_in, wdata_in, rdata_out;
    wire        wr_in, rd_in, denied_out, disable_out_pin_out, fault_out_pin_out;
    wire        rssi_alarm_clear_out, rssi_use_coarse_out, driver_level_write_out;
    wire        factory_password_level_in, user_password_level_in;
    wire        table_readwrite_grant_in, table_read_grant_in;
    wire [15:0] rssi_coarse_clamped_out, bias_monitor_out, power_monitor_out;
    wire [9:0]  dac_out;
    wire [1:0]  driver_level_field_out;
    integer     fail_count = 0;
    integer     total_checks = 0;
    integer     k;
    // 20 MHz clock
    initial forever #25 clk_in = ~clk_in;
    assign {table_read_grant_in, table_readwrite_grant_in, user_password_level_in,
            factory_password_level_in} = grants;
    // Thresholds step by one around 8000h fine and 4000h coarse
    monitor_txctl_config_regs dut_u (
        .crossover_threshold_fine_in  (crossover_threshold_fine),
        .crossover_threshold_coarse_in(crossover_threshold_coarse),
        .fault_other_in               (1'b0),
        .*
    );
    config_host host_u (
        .clk_in   (clk_in),
        .rdata_in (rdata_out),
        .denied_in(denied_out),
        .addr_out (addr_in),
        .wr_out   (wr_in),
        .rd_out   (rd_in),
        .wdata_out(wdata_in)
    );
    // ==========================================
    // Compare and close
    task check(input [63:0] name, input [15:0] exp, input [15:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, fail_count);
            if (fail_count == 0 && total_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // Watchdog, about twice the expected run
    initial begin
        repeat (5000) @(posedge clk_in);
        fail_count = fail_count + 1;
        end_of_test;
    end
    // ==========================================
    // Test sequence
    initial begin
        {nv_load_in, disable_in, fault_in_pin_in, bias_overflow_flag_in} = 4'h0;
        {modulation_overflow_flag_in, hysteresis_coarse_in, sh} = 10'h000;
        {nv_config_c_in, nv_config_d_in, nv_shift_in, dac_raw_in, lower_power_level_in} = 36'h0;
        {rssi_fine_raw_in, rssi_coarse_raw_in, bias_monitor_in, power_monitor_in} = 64'h0;
        {crossover_threshold_fine, crossover_threshold_coarse} = 32'h80004000;
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        grants <= 4'h1;
        host_u.put(8'h8C, 8'hFF, den);
        for (k = 0; k < 5; k = k + 1) begin
            host_u.get(8'h8B + k, q, den);
            check("reset", k == 0 ? 8'h10 : 8'h00, q);
        end
        $display("reset done");
        for (k = 0; k < 16; k = k + 1) begin
            @(posedge clk_in);
            grants <= k[3:0];
            wok = k[0] | (k[1] & k[2]);
            rok = k[0] | (k[1] & (k[2] | k[3]));
            host_u.put(8'h8E, {~k[3:0], k[3:0]}, den);
            check("wr deny", !wok, den);
            if (wok)
                sh = {~k[3:0], k[3:0]} & 8'h77;
            host_u.get(8'h8E, q, den);
            check("rd deny", !rok, den);
            check("rd data", rok ? sh : 8'h00, q);
        end
        @(posedge clk_in);
        grants <= 4'h1;
        $display("access done");
        for (k = 0; k < 512; k = k + 1) begin
            @(posedge clk_in);
            {disable_in, fault_in_pin_in, hysteresis_coarse_in} <= {k[8], k[0] ^ k[8], k[5] ^ k[1]};
            {bias_overflow_flag_in, modulation_overflow_flag_in} <= {k[6] & k[1], k[6] & ~k[1]};
            rssi_fine_raw_in <= k[3] ? 16'h8001 : 16'h8000;
            rssi_coarse_raw_in <= k[2] ? 16'h3FFF : 16'h4000;
            crossover_threshold_fine <= k[4] ? 16'h7FFF : 16'h8000;
            crossover_threshold_coarse <= k[4] ? 16'h4001 : 16'h4000;
            cfg = k[7:0];
            host_u.put(8'h8B, cfg, den);
            @(posedge clk_in);
            #1;
            ex = {disable_in & ~cfg[2] | fault_in_pin_in & cfg[3]};
            check("dis", ex, disable_out_pin_out);
            ex = {cfg[4] & (bias_overflow_flag_in | modulation_overflow_flag_in)};
            check("flt", ex, fault_out_pin_out);
            check("alarm", {cfg[5] & disable_in}, rssi_alarm_clear_out);
            // Crossover: raw fine above the threshold asks for coarse
            ex = {cfg[7] ? k[3] | k[4] : hysteresis_coarse_in};
            ex = {cfg[1:0] == 2'b10 | cfg[1:0] != 2'b01 & ex[0]};
            check("coarse", ex, rssi_use_coarse_out);
            ex = cfg[7] & (k[2] | k[4]) ? crossover_threshold_coarse : rssi_coarse_raw_in;
            check("clamp", ex, rssi_coarse_clamped_out);
        end
        host_u.get(8'h8B, q, den);
        check("cfg c", 8'hBF, q);
        $display("pins done");
        for (k = 0; k < 32; k = k + 1) begin
            @(posedge clk_in);
            dac_raw_in <= k[0] ? 10'h25A : 10'h1A5;
            lower_power_level_in <= k[1] ? 2'h2 : {1'b0, k[0]};
            cfg = {k[4], 3'h7, k[3:0]};
            host_u.put(8'h8D, cfg, den);
            @(posedge clk_in);
            #1;
            check("dac", cfg[7] ? dac_raw_in : {~dac_raw_in}, dac_out);
            ex = cfg[2:0] < 3'h3 ? 16'h0 : cfg[2:0] < 3'h6 ? 16'h1 : 16'h2;
            if (!cfg[3])
                ex = lower_power_level_in;
            check("level", ex, driver_level_field_out);
            check("lvl wr", cfg[3], driver_level_write_out);
        end
        host_u.get(8'h8D, q, den);
        check("cfg d", 8'h8F, q);
        for (k = 0; k < 8; k = k + 1) begin
            @(posedge clk_in);
            bias_monitor_in <= 16'hA5C3 ^ k[15:0];
            power_monitor_in <= 16'hF00F + k[15:0];
            host_u.put(8'h8E, {1'b1, k[2:0], 1'b1, ~k[2:0]}, den);
            @(posedge clk_in);
            #1;
            check("bias", bias_monitor_in >> k[2:0], bias_monitor_out);
            check("power", power_monitor_in >> ~k[2:0], power_monitor_out);
        end
        $display("level done");
        @(posedge clk_in);
        {nv_config_c_in, nv_config_d_in, nv_shift_in} <= 24'h4AF35C;
        nv_load_in <= 1'b1;
        @(posedge clk_in);
        nv_load_in <= 1'b0;
        host_u.get(8'h8B, q, den);
        check("nv c", 8'h0A, q);
        host_u.get(8'h8D, q, den);
        check("nv d", 8'h83, q);
        host_u.get(8'h8E, q, den);
        check("nv s", 8'h54, q);
        $display("recall done");
        end_of_test;
    end
endmodule
